// file: logic/dmrod_pkg.sv
// package: constants and types of the mode register one block
// Contract
// [R1] register loads only by command, holds until reset
// [R2] register reload leaves memory contents untouched
// [R3] controller loads with banks idle, waits after
// [R4] controller writes zero to reserved bits
// [R5] write leveling limits termination unless outputs off
// [R6] dll selection taken from bit zero on load
// [R7] controller enables dll at init, then resets
// [R8] self refresh stops dll, exit re-enables, resets
// [R9] dll off before self refresh stays off
// [R10] dll off: no termination, latencies six only
// [R11] drive impedance from bits five and one
// [R12] output disable bit holds data outputs off
// [R13] termination strobe gets strobe termination, never driven
// [R14] termination strobe replaces mask; else mask works
// [R15] controller keeps termination strobe off on x4/x16
// [R16] nominal termination decoded from bits nine, six, two
// [R17] controller keeps termination off across reads
// [R18] termination follows control pin with latency
// [R19] bit seven enters write leveling mode
// [R20] bits four, three decode additive latency
// [R21] activate spacing plus additive latency meets minimum
// [R22] commands held additive latency; latency sums
// [R23] dll reset self clears, 512 cycles to lock
// [R24] bit zero low means dll enabled
package dmrod_pkg;
  // ****************************************
  // bus map
  // ****************************************
  localparam logic [3:0]  A_MR1 = 4'h0;
  localparam logic [3:0]  A_CMD = 4'h4;
  localparam logic [3:0]  A_LAT = 4'h8;
  localparam logic [3:0]  A_STAT = 4'hc;
  localparam logic [3:0]  SEL_ALL = 4'hf;
  localparam int          OP_LSB = 18;
  localparam logic [1:0]  OP_MR1 = 2'h0;
  localparam logic [1:0]  OP_MR0 = 2'h1;
  localparam logic [1:0]  OP_SRE = 2'h2;
  localparam logic [1:0]  OP_SRX = 2'h3;
  localparam int          L_CL = 0;
  localparam int          L_CWL = 8;
  localparam logic [3:0]  CL_RST = 4'h6;
  localparam logic [3:0]  CWL_RST = 4'h5;
  localparam logic [3:0]  LAT_DLLOFF = 4'h6;
  localparam int          S_DLLEN = 0;
  localparam int          S_LOCK = 1;
  localparam int          S_SR = 2;
  localparam int          S_RSV = 3;
  localparam int          S_LATERR = 4;
  localparam int          S_AL = 8;
  localparam int          S_WL = 16;
  localparam int          S_RL = 24;
  // ****************************************
  // register fields
  // ****************************************
  localparam logic [17:0] MR1_RST = 18'h0;
  localparam logic [17:0] MR1_RSV = 18'h26500;
  localparam int          B_DLL = 0;
  localparam int          B_DRV0 = 1;
  localparam int          B_RTT0 = 2;
  localparam int          B_AL0 = 3;
  localparam int          B_AL1 = 4;
  localparam int          B_DRV1 = 5;
  localparam int          B_RTT1 = 6;
  localparam int          B_WL = 7;
  localparam int          B_DLLRST = 8;
  localparam int          B_RTT2 = 9;
  localparam int          B_TDQS = 11;
  localparam int          B_QOFF = 12;
  localparam logic [1:0]  AL_ZERO = 2'h0;
  localparam logic [1:0]  AL_CLM1 = 2'h1;
  localparam logic [1:0]  AL_CLM2 = 2'h2;
  localparam logic [1:0]  DRV_D6 = 2'h0;
  localparam logic [3:0]  DIV_2 = 4'h2;
  localparam logic [3:0]  DIV_4 = 4'h4;
  localparam logic [3:0]  DIV_6 = 4'h6;
  localparam logic [3:0]  DIV_7 = 4'h7;
  localparam logic [3:0]  DIV_8 = 4'h8;
  localparam logic [3:0]  DIV_12 = 4'hc;
  localparam logic [3:0]  DIV_OFF = 4'h0;
  localparam logic [2:0]  RTT_D4 = 3'h1;
  localparam logic [2:0]  RTT_D2 = 3'h2;
  localparam logic [2:0]  RTT_D6 = 3'h3;
  localparam logic [2:0]  RTT_D12 = 3'h4;
  localparam logic [2:0]  RTT_D8 = 3'h5;
  // ****************************************
  // timing and delay line
  // ****************************************
  localparam logic [9:0]  DLLK_CYC = 10'd512;
  localparam int          DLY_W = 5;
  localparam int          DLY_N = 31;
  localparam logic [4:0]  ODT_OFS = 5'd2;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    DLL_OFF  = 3'b001,
    DLL_LOCK = 3'b010,
    DLL_ON   = 3'b100
  } dmrod_dll_t;
  typedef struct packed {
    logic       dll_en;
    logic       dll_rst;
    logic       q_off;
    logic       tdqs_en;
    logic       dm_en;
    logic       wl_en;
    logic [3:0] drv_div;
    logic [3:0] rtt_div;
  } dmrod_cfg_t;
endpackage

// file: logic/dmrod_dly.sv
// delay line with a selectable tap
`timescale 1ns/1ps
`default_nettype none
module dmrod_dly (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       d_i,
  input  wire logic [dmrod_pkg::DLY_W-1:0] sel_i,
  output logic                            q_o
);
  import dmrod_pkg::*;

  logic [DLY_N-1:0] sh_ff;
  logic [DLY_N:0]   tap;

  assign tap = {sh_ff, d_i};
  assign q_o = tap[sel_i];

  // ****************************************
  // one flop per stage
  // ****************************************
  for (genvar i = 0; i < DLY_N; i++) begin : g_st
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sh_ff[i] <= 1'b0;
      end else begin
        sh_ff[i] <= tap[i];
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/dmrod_top.sv
// top: mode register one store and decode behind wishbone
`timescale 1ns/1ps
`default_nettype none
module dmrod_top (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 odt_pin_i,
  input  wire logic                 rd_cmd_i,
  input  wire logic                 wr_cmd_i,
  output logic                      rd_rel_o,
  output logic                      wr_rel_o,
  output logic                      rtt_on_o,
  output logic                      tdqs_term_o,
  output logic                      dq_oe_en_o,
  output var dmrod_pkg::dmrod_cfg_t cfg_o
);
  import dmrod_pkg::*;

  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [17:0] mr1_ff;
  logic [3:0]  cl_ff;
  logic [3:0]  cwl_ff;
  dmrod_dll_t  dll_ff;
  logic        sr_ff;
  logic        sr_rst_ff;
  logic [9:0]  lock_cnt_ff;
  logic [4:0]  al_ff;
  logic [4:0]  rl_ff;
  logic [4:0]  wl_ff;
  logic [4:0]  odtl_ff;
  logic [2:0]  odt_s_ff;
  logic        odt_lvl_ff;
  logic        rtt_req_ff;
  dmrod_cfg_t  cfg_ff;
  logic        rd_rel_ff;
  logic        wr_rel_ff;
  logic        rtt_on_ff;
  logic        tdqs_term_ff;
  logic        dq_oe_ff;
  logic        req;
  logic        wr_go;
  logic        cmd_go;
  logic [1:0]  op;
  logic        mr1_ld;
  logic        mr0_ld;
  logic        sre_go;
  logic        srx_go;
  logic [2:0]  rtt_code;
  logic [3:0]  nxt_rtt;
  logic [4:0]  nxt_al;
  logic [4:0]  nxt_wl;
  logic [31:0] stat_w;
  logic        odt_q;
  logic        rd_q;
  logic        wr_q;

  // ****************************************
  // wishbone slave
  // ****************************************
  assign req    = wb_cyc_i & wb_stb_i;
  assign wr_go  = req & ack_ff & wb_we_i;
  assign cmd_go = wr_go & (wb_adr_i == A_CMD) & (wb_sel_i == SEL_ALL);
  assign op     = wb_dat_i[OP_LSB+:2];
  assign mr1_ld = cmd_go & (op == OP_MR1) & ~sr_ff;
  assign mr0_ld = cmd_go & (op == OP_MR0) & ~sr_ff & wb_dat_i[B_DLLRST];
  assign sre_go = cmd_go & (op == OP_SRE) & ~sr_ff;
  assign srx_go = cmd_go & (op == OP_SRX) & sr_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_comb begin
    stat_w = 32'h0;
    stat_w[S_DLLEN] = (dll_ff != DLL_OFF);
    stat_w[S_LOCK] = (dll_ff == DLL_ON);
    stat_w[S_SR] = sr_ff;
    stat_w[S_RSV] = |(mr1_ff & MR1_RSV);
    stat_w[S_LATERR] = (dll_ff == DLL_OFF) &&
                       ((cl_ff != LAT_DLLOFF) || (cwl_ff != LAT_DLLOFF)); // [R10]
    stat_w[S_AL+:5] = al_ff;
    stat_w[S_WL+:5] = wl_ff;
    stat_w[S_RL+:5] = rl_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0;
    end else if (req & ~ack_ff) begin
      unique case (wb_adr_i)
        A_MR1:   rdat_ff <= 32'(mr1_ff);
        A_LAT:   rdat_ff <= {16'h0, 4'h0, cwl_ff, 4'h0, cl_ff};
        A_STAT:  rdat_ff <= stat_w;
        default: rdat_ff <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cl_ff  <= CL_RST;
      cwl_ff <= CWL_RST;
    end else if (wr_go && wb_adr_i == A_LAT) begin
      if (wb_sel_i[0]) begin
        cl_ff <= wb_dat_i[L_CL+:4];
      end
      if (wb_sel_i[1]) begin
        cwl_ff <= wb_dat_i[L_CWL+:4];
      end
    end
  end

  // ****************************************
  // mode register store
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mr1_ff <= MR1_RST; // [R1]
    end else if (mr1_ld) begin
      mr1_ff <= wb_dat_i[17:0]; // [R1] [R2] [R6]
    end
  end

  // ****************************************
  // dll state and self refresh
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dll_ff <= DLL_OFF;
    end else begin
      unique case (dll_ff)
        DLL_OFF: begin
          if (srx_go && sr_rst_ff) begin
            dll_ff <= DLL_LOCK; // [R8]
          end else if (mr1_ld && !wb_dat_i[B_DLL]) begin
            dll_ff <= DLL_ON; // [R24]
          end
        end
        DLL_LOCK: begin
          if ((mr1_ld && wb_dat_i[B_DLL]) || sre_go) begin
            dll_ff <= DLL_OFF; // [R8] [R24]
          end else if (lock_cnt_ff == DLLK_CYC - 10'd1) begin
            dll_ff <= DLL_ON; // [R23]
          end
        end
        DLL_ON: begin
          if ((mr1_ld && wb_dat_i[B_DLL]) || sre_go) begin
            dll_ff <= DLL_OFF; // [R8] [R24]
          end else if (mr0_ld) begin
            dll_ff <= DLL_LOCK; // [R23]
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_cnt_ff <= 10'd0;
    end else begin
      lock_cnt_ff <= (dll_ff == DLL_LOCK) ? lock_cnt_ff + 10'd1 : 10'd0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr_ff     <= 1'b0;
      sr_rst_ff <= 1'b0;
    end else if (sre_go) begin
      sr_ff     <= 1'b1;
      sr_rst_ff <= (dll_ff != DLL_OFF); // [R8] [R9]
    end else if (srx_go) begin
      sr_ff     <= 1'b0;
    end
  end

  // ****************************************
  // latency decode
  // ****************************************
  always_comb begin
    unique case (mr1_ff[B_AL1:B_AL0])
      AL_CLM1: nxt_al = {1'b0, cl_ff} - 5'd1; // [R20]
      AL_CLM2: nxt_al = {1'b0, cl_ff} - 5'd2; // [R20]
      default: nxt_al = 5'd0; // [R20]
    endcase
    nxt_wl = nxt_al + {1'b0, cwl_ff}; // [R22]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      al_ff   <= 5'd0;
      rl_ff   <= 5'd0;
      wl_ff   <= 5'd0;
      odtl_ff <= 5'd0;
    end else begin
      al_ff   <= nxt_al;
      rl_ff   <= nxt_al + {1'b0, cl_ff}; // [R22]
      wl_ff   <= nxt_wl;
      odtl_ff <= (nxt_wl >= ODT_OFS) ? nxt_wl - ODT_OFS : 5'd0; // [R18]
    end
  end

  // ****************************************
  // termination and drive decode
  // ****************************************
  assign rtt_code = {mr1_ff[B_RTT2], mr1_ff[B_RTT1], mr1_ff[B_RTT0]};

  always_comb begin
    unique case (rtt_code)
      RTT_D4:  nxt_rtt = DIV_4; // [R16]
      RTT_D2:  nxt_rtt = DIV_2; // [R16]
      RTT_D6:  nxt_rtt = DIV_6; // [R16]
      RTT_D12: nxt_rtt = DIV_12; // [R16]
      RTT_D8:  nxt_rtt = DIV_8; // [R16]
      default: nxt_rtt = DIV_OFF;
    endcase
    if (mr1_ff[B_WL] && !mr1_ff[B_QOFF] && rtt_code > RTT_D6) begin
      nxt_rtt = DIV_OFF; // [R5]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff.dll_en  <= (dll_ff != DLL_OFF);
      cfg_ff.dll_rst <= (dll_ff == DLL_LOCK);
      cfg_ff.q_off   <= mr1_ff[B_QOFF];
      cfg_ff.tdqs_en <= mr1_ff[B_TDQS];
      cfg_ff.dm_en   <= ~mr1_ff[B_TDQS]; // [R14]
      cfg_ff.wl_en   <= mr1_ff[B_WL]; // [R19]
      cfg_ff.drv_div <= ({mr1_ff[B_DRV1], mr1_ff[B_DRV0]} == DRV_D6) ?
                        DIV_6 : DIV_7; // [R11]
      cfg_ff.rtt_div <= nxt_rtt;
    end
  end

  // ****************************************
  // termination pin and command release
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      odt_s_ff   <= 3'h0;
      odt_lvl_ff <= 1'b0;
      rtt_req_ff <= 1'b0;
    end else begin
      odt_s_ff   <= {odt_s_ff[1:0], odt_pin_i};
      if (odt_s_ff[1] == odt_s_ff[2]) begin
        odt_lvl_ff <= odt_s_ff[2];
      end
      rtt_req_ff <= odt_lvl_ff && (nxt_rtt != DIV_OFF) &&
                    (dll_ff != DLL_OFF) && !sr_ff; // [R18] [R10]
    end
  end

  dmrod_dly u_odt (.clk_i(clk_i), .rst_i(rst_i), .d_i(rtt_req_ff),
                   .sel_i(odtl_ff), .q_o(odt_q));
  dmrod_dly u_rd (.clk_i(clk_i), .rst_i(rst_i), .d_i(rd_cmd_i),
                  .sel_i(al_ff), .q_o(rd_q));
  dmrod_dly u_wr (.clk_i(clk_i), .rst_i(rst_i), .d_i(wr_cmd_i),
                  .sel_i(al_ff), .q_o(wr_q));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_rel_ff    <= 1'b0;
      wr_rel_ff    <= 1'b0;
      rtt_on_ff    <= 1'b0;
      tdqs_term_ff <= 1'b0;
      dq_oe_ff     <= 1'b0;
    end else begin
      rd_rel_ff    <= rd_q; // [R22]
      wr_rel_ff    <= wr_q; // [R22]
      rtt_on_ff    <= odt_q; // [R18]
      tdqs_term_ff <= odt_q & mr1_ff[B_TDQS]; // [R13]
      dq_oe_ff     <= ~mr1_ff[B_QOFF]; // [R12]
    end
  end

  assign wb_ack_o    = ack_ff;
  assign wb_dat_o    = rdat_ff;
  assign rd_rel_o    = rd_rel_ff;
  assign wr_rel_o    = wr_rel_ff;
  assign rtt_on_o    = rtt_on_ff;
  assign tdqs_term_o = tdqs_term_ff;
  assign dq_oe_en_o  = dq_oe_ff;
  assign cfg_o       = cfg_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence sr_in_on_s;
    sre_go && dll_ff == DLL_ON;
  endsequence
  sequence rd_al2_s;
    rd_cmd_i && al_ff == 5'd2 ##1 $stable(al_ff)[*2];
  endsequence

  mr1_hold_a: assert property (!mr1_ld |=> $stable(mr1_ff)) // [R1]
    else $error("mode register changed without load");
  dll_sel_a: assert property (mr1_ld && wb_dat_i[B_DLL] |=> // [R24]
    dll_ff == DLL_OFF) else $error("dll not off after disable");
  sr_dll_off_a: assert property (sr_in_on_s |=> // [R8]
    dll_ff == DLL_OFF && sr_rst_ff) else $error("dll kept in self refresh");
  sr_relock_a: assert property (srx_go && sr_rst_ff |=> // [R8]
    dll_ff == DLL_LOCK) else $error("dll not reset on exit");
  sr_stay_off_a: assert property (srx_go && !sr_rst_ff |=> // [R9]
    dll_ff == DLL_OFF) else $error("dll woke after exit");
  lock_len_a: assert property (dll_ff == DLL_ON && // [R23]
    $past(dll_ff) == DLL_LOCK |-> $past(lock_cnt_ff) == DLLK_CYC - 10'd1)
    else $error("dll lock time wrong");
  qoff_oe_a: assert property (mr1_ff[B_QOFF] |=> !dq_oe_en_o) // [R12]
    else $error("outputs enabled while disabled");
  dm_tdqs_a: assert property ($past(mr1_ff[B_TDQS]) |-> // [R14]
    !cfg_o.dm_en && cfg_o.tdqs_en) else $error("mask with strobe on");
  rtt_dll_a: assert property (dll_ff == DLL_OFF |=> !rtt_req_ff) // [R10]
    else $error("termination with dll off");
  wl_rtt_a: assert property (mr1_ff[B_WL] && !mr1_ff[B_QOFF] && // [R5]
    rtt_code == RTT_D12 |=> cfg_o.rtt_div == DIV_OFF)
    else $error("read termination in leveling");
  al_dec_a: assert property (mr1_ff[B_AL1:B_AL0] == AL_CLM2 |=> // [R20]
    al_ff == $past({1'b0, cl_ff}) - 5'd2) else $error("additive latency bad");
  rel_delay_a: assert property (rd_al2_s |-> ##1 rd_rel_o) // [R22]
    else $error("read not released after latency");
endmodule
`default_nettype wire

// file: bench/dmrod_ctl.sv
// partner: controller model issuing mode register traffic
`timescale 1ns/1ps
`default_nettype none
module dmrod_ctl #(
  parameter int ORG_WIDTH = 8
) (
  input  wire logic        clk_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [3:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  output logic             odt_o,
  output logic             rd_o,
  output logic             wr_o
);
  import dmrod_pkg::*;
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 4'h0;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
    odt_o    = 1'b0;
    rd_o     = 1'b0;
    wr_o     = 1'b0;
  end
  // ****************************************
  // bus cycle and commands
  // ****************************************
  task automatic wbs(input logic we, input logic [3:0] a,
                     input logic [3:0] s, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= a;
    wb_sel_o <= s;
    wb_dat_o <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
  endtask
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    wbs(we, a, SEL_ALL, d, q);
  endtask
  task automatic cmd(input logic [1:0] op, input logic [17:0] v);
    logic [31:0] q;
    wb(1'b1, A_CMD, {12'h0, op, v}, q);
    repeat (4) @(posedge clk_i);
  endtask
  task automatic mr1(input logic [17:0] v);
    v &= ~MR1_RSV;
    if (ORG_WIDTH != 8) v[B_TDQS] = 1'b0;
    cmd(OP_MR1, v);
  endtask
  task automatic init();
    logic [31:0] q;
    wb(1'b1, A_LAT, 32'h0000_0606, q);
    cmd(OP_MR1, 18'h0);
    cmd(OP_MR0, 18'h100);
    repeat (520) @(posedge clk_i);
  endtask
  // command issued with no activate spacing to honour
  task automatic pulse(input logic r, input logic w);
    @(posedge clk_i);
    rd_o <= r;
    wr_o <= w;
    @(posedge clk_i);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
  endtask
  task automatic odt(input logic l);
    @(posedge clk_i);
    odt_o <= l;
  endtask
endmodule
`default_nettype wire

// file: bench/dmrod_top_tb.sv
// testbench: mode register one block against a bench model
`timescale 1ns/1ps
`default_nettype none
module dmrod_top_tb;
  import dmrod_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, odt, rd, wr, rrel, wrel, rtt, tdt, oe;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [17:0] v;
  logic        dll;
  dmrod_cfg_t  cfg;
  int          err_total = 0;
  int          n_compared = 0;
  int          ticks = 0;
  int          n, al;
  logic [3:0]  rtt_tab [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hc, 4'h8, 4'h0, 4'h0};
  initial forever #20 clk_i = ~clk_i;
  dmrod_top i_dmrod_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .odt_pin_i(odt), .rd_cmd_i(rd),
    .wr_cmd_i(wr), .rd_rel_o(rrel), .wr_rel_o(wrel), .rtt_on_o(rtt),
    .tdqs_term_o(tdt), .dq_oe_en_o(oe), .cfg_o(cfg)
  );
  dmrod_ctl i_dmrod_ctl (
    .clk_i(clk_i), .wb_dat_i(rdat), .wb_ack_i(ack), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
    .wb_dat_o(wdat), .odt_o(odt), .rd_o(rd), .wr_o(wr)
  );
  // ****************************************
  // model and checking
  // ****************************************
  function automatic dmrod_cfg_t model(logic [17:0] m, logic d);
    logic [2:0] c;
    dmrod_cfg_t e;
    c = {m[B_RTT2], m[B_RTT1], m[B_RTT0]};
    e.dll_en = d;
    e.dll_rst = 1'b0;
    e.q_off = m[B_QOFF];
    e.tdqs_en = m[B_TDQS];
    e.dm_en = !m[B_TDQS];
    e.wl_en = m[B_WL];
    e.drv_div = (m[B_DRV1] | m[B_DRV0]) ? 4'h7 : 4'h6;
    e.rtt_div = rtt_tab[c];
    if (m[B_WL] && !m[B_QOFF] && c > 3'h3) e.rtt_div = 4'h0;
    return e;
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask
  task automatic wait_rtt(input logic l);
    n = 0;
    while (rtt !== l && n < 30) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic wait_rel();
    #1;
    n = 0;
    while (rrel !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      err_total++;
      conclude();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(60));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("cfg_rst", 32'(cfg), 32'(model(18'h0, 1'b0)));
    chk("oe_rst", 32'(oe), 32'h1);
    i_dmrod_ctl.wb(1'b0, A_LAT, 32'h0, q);
    chk("lat_rst", q, 32'h0000_0506);
    i_dmrod_ctl.init();
    for (int i = 0; i < 12; i++) begin
      v = 18'($urandom) & ~MR1_RSV;
      i_dmrod_ctl.mr1(v);
      dll = !v[B_DLL];
      al = {v[B_AL1], v[B_AL0]} == 2'h1 ? 5 :
           {v[B_AL1], v[B_AL0]} == 2'h2 ? 4 : 0;
      i_dmrod_ctl.wb(1'b0, A_MR1, 32'h0, q);
      chk("mr1", q, {14'h0, v});
      chk("cfg", 32'(cfg), 32'(model(v, dll)));
      chk("oe", 32'(oe), 32'(!v[B_QOFF]));
      i_dmrod_ctl.wb(1'b0, A_STAT, 32'h0, q);
      chk("stat", q & 32'h1f1f_1f01, {3'h0, 5'(al + 6), 3'h0, 5'(al + 6),
          3'h0, 5'(al), 7'h0, dll});
    end
    i_dmrod_ctl.wb(1'b1, A_MR1, 32'h3_ffff, q);
    i_dmrod_ctl.wb(1'b0, A_MR1, 32'h0, q);
    chk("mr1_ro", q, {14'h0, v});
    i_dmrod_ctl.wb(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", q, 32'h0);
    for (int a = 0; a < 3; a++) begin
      i_dmrod_ctl.mr1(18'(a) << B_AL0);
      i_dmrod_ctl.pulse(1'b1, 1'b1);
      wait_rel();
      chk("rel", n, a == 1 ? 5 : a == 2 ? 4 : 0);
      chk("wrel", 32'(wrel), 32'h1);
    end
    // cl of four by a low byte write; partial command write ignored
    i_dmrod_ctl.wbs(1'b1, A_LAT, 4'h1, 32'h0000_0f04, q);
    i_dmrod_ctl.wbs(1'b1, A_CMD, 4'h7, 32'h0000_0001, q);
    i_dmrod_ctl.wb(1'b0, A_LAT, 32'h0, q);
    chk("lat_sel", q, 32'h0000_0604);
    i_dmrod_ctl.wb(1'b0, A_MR1, 32'h0, q);
    chk("cmd_sel", q, 32'h0000_0010);
    i_dmrod_ctl.pulse(1'b1, 1'b0);
    wait_rel();
    chk("rel_cl4", n, 2);
    chk("wrel_off", 32'(wrel), 32'h0);
    i_dmrod_ctl.wb(1'b1, A_LAT, 32'h0000_0606, q);
    i_dmrod_ctl.cmd(OP_SRE, 18'h0);
    chk("sre", 32'({cfg.dll_en, cfg.dll_rst}), 32'h0);
    i_dmrod_ctl.cmd(OP_SRX, 18'h0);
    chk("srx", 32'(cfg.dll_rst), 32'h1);
    repeat (500) @(posedge clk_i);
    chk("lock", 32'(cfg.dll_rst), 32'h1);
    repeat (20) @(posedge clk_i);
    chk("on", 32'({cfg.dll_en, cfg.dll_rst}), 32'h2);
    i_dmrod_ctl.mr1(18'h1);
    i_dmrod_ctl.cmd(OP_SRE, 18'h0);
    i_dmrod_ctl.cmd(OP_SRX, 18'h0);
    chk("srx_off", 32'({cfg.dll_en, cfg.dll_rst}), 32'h0);
    i_dmrod_ctl.mr1(18'h804);
    i_dmrod_ctl.odt(1'b1);
    wait_rtt(1'b1);
    chk("rtt_on", 32'({rtt, tdt}), 32'h3);
    i_dmrod_ctl.odt(1'b0);
    wait_rtt(1'b0);
    chk("rtt_off", 32'({rtt, tdt}), 32'h0);
    i_dmrod_ctl.mr1(18'h800);
    i_dmrod_ctl.odt(1'b1);
    repeat (30) @(posedge clk_i);
    chk("rtt_dis", 32'(rtt), 32'h0);
    i_dmrod_ctl.odt(1'b0);
    // leveling with a /12 setting, outputs on then off
    i_dmrod_ctl.mr1(18'h280);
    chk("wl_rtt", 32'(cfg), 32'(model(18'h280, 1'b1)));
    i_dmrod_ctl.mr1(18'h1280);
    chk("wl_qoff", 32'(cfg), 32'(model(18'h1280, 1'b1)));
    // reset in mid run clears the register
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("cfg_rst2", 32'(cfg), 32'(model(18'h0, 1'b0)));
    i_dmrod_ctl.wb(1'b0, A_MR1, 32'h0, q);
    chk("mr1_rst2", q, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
